/* File: hw/rllc_codec.sv */
// Eight-to-sixteen run-length limited encoder and stateless decoder
`timescale 1ns/1ps
`default_nettype none
module rllc_codec
    import rllc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic tbl_wr_en,
    input wire logic [9:0] tbl_wr_addr,
    input wire logic [15:0] tbl_wr_code,
    input wire logic [1:0] tbl_wr_next,
    input wire logic rx_valid,
    input wire logic [15:0] rx_word,
    output logic code_valid,
    output logic [15:0] code_word,
    output logic [1:0] enc_state,
    output logic dec_valid,
    output logic [7:0] dec_byte,
    output logic dec_miss
);
    rllc_tbl_if tb();

    rllc_table u_table (
        .ref_clk(ref_clk),
        .tb(tb)
    );

    // Encoder state
    rllc_state_t state_q, state_d;
    rllc_state_t src_q, src_d;
    logic code_valid_q, code_valid_d;
    logic [15:0] code_q, code_d;
    logic [15:0] prev_code_q, prev_code_d;
    logic seen_q, seen_d;
    logic prev_ok_q, prev_ok_d;

    assign tb.wr_en = tbl_wr_en;
    assign tb.wr_addr = tbl_wr_addr;
    assign tb.wr_code = tbl_wr_code;
    assign tb.wr_next = rllc_state_t'(tbl_wr_next);
    assign tb.enc_addr = {byte_data, state_q};

    always_comb begin
        state_d = state_q;
        src_d = src_q;
        code_valid_d = 1'b0;
        code_d = code_q;
        prev_code_d = prev_code_q;
        seen_d = seen_q;
        prev_ok_d = prev_ok_q;
        if (byte_valid) begin
            code_valid_d = 1'b1;
            code_d = tb.enc_code;
            state_d = tb.enc_next;
            src_d = state_q;
            prev_code_d = code_q;
            prev_ok_d = seen_q;
            seen_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= RLLC_ST_RESET;
            src_q <= RLLC_ST_RESET;
            code_valid_q <= 1'b0;
            code_q <= 16'h0000;
            prev_code_q <= 16'h0000;
            seen_q <= 1'b0;
            prev_ok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            code_valid_q <= code_valid_d;
            code_q <= code_d;
            prev_code_q <= prev_code_d;
            seen_q <= seen_d;
            prev_ok_q <= prev_ok_d;
        end
    end

    // Decoder state: a word is held until its successor shows its marker bits
    logic [15:0] hold_q, hold_d;
    logic pend_q, pend_d;
    logic dvalid_q, dvalid_d;
    logic [7:0] dbyte_q, dbyte_d;
    logic dmiss_q, dmiss_d;

    assign tb.srch_word = hold_q;
    assign tb.srch_mark = {rx_word[RLLC_MARK_HI], rx_word[RLLC_MARK_LO]};

    always_comb begin
        hold_d = hold_q;
        pend_d = pend_q;
        dvalid_d = 1'b0;
        dbyte_d = dbyte_q;
        dmiss_d = dmiss_q;
        if (rx_valid) begin
            hold_d = rx_word;
            pend_d = 1'b1;
            if (pend_q) begin
                dvalid_d = 1'b1;
                dbyte_d = tb.srch_byte;
                dmiss_d = !tb.srch_hit;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 16'h0000;
            pend_q <= 1'b0;
            dvalid_q <= 1'b0;
            dbyte_q <= 8'h00;
            dmiss_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            pend_q <= pend_d;
            dvalid_q <= dvalid_d;
            dbyte_q <= dbyte_d;
            dmiss_q <= dmiss_d;
        end
    end

    assign code_valid = code_valid_q;
    assign code_word = code_q;
    assign enc_state = state_q;
    assign dec_valid = dvalid_q;
    assign dec_byte = dbyte_q;
    assign dec_miss = dmiss_q;

    // Bit lengths of the zero runs at the edges of words
    logic [4:0] cur_lead, cur_trail, prev_trail;
    // One bit wider: two empty words would give sixteen zeros each
    logic [5:0] join_run;
    assign cur_lead = rllc_lead0(code_q);
    assign cur_trail = rllc_trail0(code_q);
    assign prev_trail = rllc_trail0(prev_code_q);
    assign join_run = {1'b0, prev_trail} + {1'b0, cur_lead};

    a_one_word_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
        byte_valid |=> code_valid_q ##1 (!code_valid_q || $past(byte_valid)))
        else $error("byte did not yield exactly one code word");

    a_word_from_table: assert property (@(posedge ref_clk) disable iff (!rst_b)
        byte_valid |=> (code_q == $past(tb.enc_code)) && (state_q == $past(tb.enc_next))
            && (src_q == $past(state_q)))
        else $error("code word or next state not taken from lookup");

    a_join_run_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && prev_ok_q) |-> (join_run >= RLLC_RUN_MIN && join_run <= RLLC_RUN_MAX))
        else $error("zero run across word border out of range");

    a_state2_marks: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && src_q == RLLC_ST2) |-> (!code_q[15] && !code_q[3]))
        else $error("State 2 word has a marker bit set");

    a_state3_marks: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && src_q == RLLC_ST3) |-> (code_q[15] || code_q[3]))
        else $error("State 3 word has no marker bit set");

    a_short_tail_st1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && cur_trail <= RLLC_TRAIL_S1_MAX) |-> state_q == RLLC_ST1)
        else $error("short trailing run did not lead to State 1");

    a_st1_lead_run: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && src_q == RLLC_ST1)
            |-> (cur_lead >= RLLC_LEAD_S1_MIN && cur_lead <= RLLC_LEAD_S1_MAX))
        else $error("State 1 word leading run out of range");

    a_mid_tail_st23: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && cur_trail > RLLC_TRAIL_S1_MAX && cur_trail <= RLLC_TRAIL_S23_MAX)
            |-> (state_q == RLLC_ST2 || state_q == RLLC_ST3))
        else $error("medium trailing run did not lead to State 2 or 3");

    a_long_tail_st4: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (code_valid_q && cur_trail > RLLC_TRAIL_S23_MAX && cur_trail <= RLLC_TRAIL_S4_MAX)
            |-> state_q == RLLC_ST4 ##1 (!code_valid_q || cur_lead <= RLLC_LEAD_S4_MAX))
        else $error("long trailing run mishandled");

    a_byte1_state1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (byte_valid && byte_data == RLLC_FIXED_BYTE && state_q == RLLC_ST1)
            |=> (code_q == RLLC_CW_B1_S12 && state_q == RLLC_ST1))
        else $error("byte 1 in State 1 wrong word or state");

    a_dec_one_lag: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rx_valid && pend_q) |=> dvalid_q && (dbyte_q == $past(tb.srch_byte)))
        else $error("decoded byte not issued one word late");

    a_dec_first_held: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rx_valid && !pend_q) |=> !dvalid_q && hold_q == $past(rx_word))
        else $error("first received word decoded without a follower");
endmodule : rllc_codec
`default_nettype wire

/* File: hw/rllc_table.sv */
// Conversion table store with encoder lookup and decoder reverse search
`timescale 1ns/1ps
`default_nettype none
module rllc_table
    import rllc_pkg::*;
(
    input wire logic ref_clk,
    rllc_tbl_if.store tb
);
    logic [17:0] mem [RLLC_TBL_DEPTH];

    // Byte 1 is fixed so the codec works before any table load
    function automatic logic [17:0] entry(input logic [9:0] a);
        logic [17:0] e;
        e = mem[a];
        if (a[9:2] == RLLC_FIXED_BYTE) begin
            if (a[1:0] == RLLC_ST1 || a[1:0] == RLLC_ST2) e = {RLLC_CW_B1_S12, RLLC_NX_B1_S12};
            else e = {RLLC_CW_B1_S34, RLLC_NX_B1_S34};
        end
        return e;
    endfunction : entry

    always_ff @(posedge ref_clk) begin
        if (tb.wr_en) begin
            mem[tb.wr_addr] <= {tb.wr_code, tb.wr_next};
        end
    end

    always_comb begin
        logic [17:0] e;
        e = entry(tb.enc_addr);
        tb.enc_code = e[17:2];
        tb.enc_next = rllc_state_t'(e[1:0]);
    end

    // Stateless decode: scan every byte and state for this word
    always_comb begin
        logic [17:0] e;
        logic [9:0] a;
        e = 18'h0_0000;
        a = 10'h000;
        tb.srch_hit = 1'b0;
        tb.srch_byte = 8'h00;
        for (int i = 0; i < RLLC_TBL_DEPTH; i++) begin
            a = i[9:0];
            e = entry(a);
            // Equal words out of one state part by their next state
            if (!tb.srch_hit && e[17:2] == tb.srch_word
                && rllc_next_ok(rllc_state_t'(e[1:0]), tb.srch_mark)) begin
                tb.srch_hit = 1'b1;
                tb.srch_byte = a[9:2];
            end
        end
    end
endmodule : rllc_table
`default_nettype wire

/* File: include/rllc_pkg.sv */
// Constants, types and helpers shared by the 8-to-16 run-length codec
`default_nettype none
package rllc_pkg;
    typedef enum logic [1:0] {
        RLLC_ST1 = 2'b00,
        RLLC_ST2 = 2'b01,
        RLLC_ST3 = 2'b10,
        RLLC_ST4 = 2'b11
    } rllc_state_t;

    localparam rllc_state_t RLLC_ST_RESET = RLLC_ST1;
    localparam int RLLC_BYTE_W = 8;
    localparam int RLLC_WORD_W = 16;
    localparam int RLLC_TBL_DEPTH = 1024;
    localparam int RLLC_ADDR_W = 10;
    // Marker bits of the following word that split State 2 from State 3
    localparam int RLLC_MARK_HI = 15;
    localparam int RLLC_MARK_LO = 3;
    // Built-in entries for byte value 1
    localparam logic [7:0] RLLC_FIXED_BYTE = 8'h01;
    localparam logic [15:0] RLLC_CW_B1_S12 = 16'h2012;
    localparam logic [15:0] RLLC_CW_B1_S34 = 16'h8120;
    localparam rllc_state_t RLLC_NX_B1_S12 = RLLC_ST1;
    localparam rllc_state_t RLLC_NX_B1_S34 = RLLC_ST3;
    // Run-length limits in channel bits
    localparam logic [4:0] RLLC_RUN_MIN = 5'h02;
    localparam logic [4:0] RLLC_RUN_MAX = 5'h0a;
    localparam logic [4:0] RLLC_LEAD_S1_MIN = 5'h02;
    localparam logic [4:0] RLLC_LEAD_S1_MAX = 5'h09;
    localparam logic [4:0] RLLC_TRAIL_S1_MAX = 5'h01;
    localparam logic [4:0] RLLC_TRAIL_S23_MAX = 5'h05;
    localparam logic [4:0] RLLC_TRAIL_S4_MAX = 5'h09;
    localparam logic [4:0] RLLC_LEAD_S4_MAX = 5'h01;

    function automatic logic [4:0] rllc_lead0(input logic [15:0] w);
        logic [4:0] n;
        logic stop;
        n = 5'h00;
        stop = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (w[i]) stop = 1'b1;
            else if (!stop) n = n + 5'h01;
        end
        return n;
    endfunction : rllc_lead0

    function automatic logic [4:0] rllc_trail0(input logic [15:0] w);
        logic [4:0] n;
        logic stop;
        n = 5'h00;
        stop = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (w[i]) stop = 1'b1;
            else if (!stop) n = n + 5'h01;
        end
        return n;
    endfunction : rllc_trail0

    // Does a word's next state agree with the marker bits of the word after it
    function automatic logic rllc_next_ok(input rllc_state_t nx, input logic [1:0] mark);
        logic ok;
        ok = 1'b1;
        if (nx == RLLC_ST2) ok = (mark == 2'h0);
        if (nx == RLLC_ST3) ok = (mark != 2'h0);
        return ok;
    endfunction : rllc_next_ok
endpackage : rllc_pkg
`default_nettype wire

/* File: include/rllc_tbl_if.sv */
// Conversion table access between the codec core and its table store
`timescale 1ns/1ps
`default_nettype none
interface rllc_tbl_if;
    import rllc_pkg::*;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [15:0] wr_code;
    rllc_state_t wr_next;
    logic [9:0] enc_addr;
    logic [15:0] enc_code;
    rllc_state_t enc_next;
    logic [15:0] srch_word;
    logic [1:0] srch_mark;
    logic srch_hit;
    logic [7:0] srch_byte;
    modport core (output wr_en, wr_addr, wr_code, wr_next, enc_addr, srch_word, srch_mark,
        input enc_code, enc_next, srch_hit, srch_byte);
    modport store (input wr_en, wr_addr, wr_code, wr_next, enc_addr, srch_word, srch_mark,
        output enc_code, enc_next, srch_hit, srch_byte);
endinterface : rllc_tbl_if
`default_nettype wire

/* File: sim/rllc_chan_model.sv */
// Recording channel model: loops each code word back into the decoder input
`timescale 1ns/1ps
`default_nettype none
module rllc_chan_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic code_valid,
    input wire logic [15:0] code_word,
    input wire logic corrupt,
    output logic rx_valid,
    output logic [15:0] rx_word
);
    // Idle word toggles so a stale value is never mistaken for data
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid <= 1'b0;
            rx_word <= 16'h5a5a;
        end else begin
            rx_valid <= code_valid;
            rx_word <= code_valid ? (code_word ^ {16{corrupt}}) : ~rx_word;
        end
    end
endmodule : rllc_chan_model
`default_nettype wire

/* File: sim/rllc_codec_tb.sv */
// Testbench for the run-length codec: table walk, loop-back decode, corrupt word
`timescale 1ns/1ps
`default_nettype none
module rllc_codec_tb
    import rllc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic tbl_wr_en = 1'b0;
    logic [9:0] tbl_wr_addr = 10'h000;
    logic [15:0] tbl_wr_code = 16'h0000;
    logic [1:0] tbl_wr_next = 2'h0;
    logic corrupt = 1'b0;
    logic rx_valid, code_valid, dec_valid, dec_miss;
    logic [15:0] rx_word, code_word;
    logic [1:0] enc_state;
    logic [7:0] dec_byte;
    int n_errors = 0;
    int checked = 0;
    logic [8:0] got_q[$];
    always #2 ref_clk = ~ref_clk;
    rllc_codec rllc_codec_i (.ref_clk(ref_clk), .rst_b(rst_b), .byte_valid(byte_valid),
        .byte_data(byte_data), .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr),
        .tbl_wr_code(tbl_wr_code), .tbl_wr_next(tbl_wr_next), .rx_valid(rx_valid),
        .rx_word(rx_word), .code_valid(code_valid), .code_word(code_word),
        .enc_state(enc_state), .dec_valid(dec_valid), .dec_byte(dec_byte),
        .dec_miss(dec_miss));
    rllc_chan_model rllc_chan_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .code_valid(code_valid), .code_word(code_word), .corrupt(corrupt),
        .rx_valid(rx_valid), .rx_word(rx_word));
    always @(negedge ref_clk) begin
        if (dec_valid === 1'b1) got_q.push_back({dec_miss, dec_byte});
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // Strobe stays up across chained loads; the next send lowers it
    task automatic load(input logic [7:0] b, input logic [1:0] s, input logic [15:0] w,
        input logic [1:0] nx);
        tbl_wr_en = 1'b1;
        tbl_wr_addr = {b, s};
        tbl_wr_code = w;
        tbl_wr_next = nx;
        @(negedge ref_clk);
    endtask : load
    // Callers chain sends so bytes go back to back
    task automatic send(input logic [7:0] b, input logic [15:0] w, input logic [1:0] nx);
        tbl_wr_en = 1'b0;
        byte_valid = 1'b1;
        byte_data = b;
        @(negedge ref_clk);
        chk({15'h0000, code_valid}, 16'h0001);
        chk(code_word, w);
        chk({14'h0000, enc_state}, {14'h0000, nx});
    endtask : send
    task automatic drain_cmp(input logic [8:0] e[$]);
        byte_valid = 1'b0;
        @(negedge ref_clk);
        chk({15'h0000, code_valid}, 16'h0000);
        repeat (3) @(negedge ref_clk);
        chk(16'(got_q.size()), 16'(e.size()));
        foreach (e[i]) begin
            if (i < got_q.size()) chk({7'h00, got_q[i]}, {7'h00, e[i]});
        end
        got_q.delete();
    endtask : drain_cmp
    task automatic test_reset();
        chk({14'h0000, enc_state}, 16'h0000);
        chk(code_word, 16'h0000);
        chk({14'h0000, code_valid, dec_valid}, 16'h0000);
        chk({7'h00, dec_miss, dec_byte}, 16'h0000);
        $display("test reset done");
    endtask : test_reset
    task automatic test_builtin();
        load(8'h01, 2'h0, 16'hffff, 2'h3);
        send(8'h01, RLLC_CW_B1_S12, RLLC_ST1);
        send(8'h01, RLLC_CW_B1_S12, RLLC_ST1);
        drain_cmp('{9'h001});
        $display("test built-in done");
    endtask : test_builtin
    task automatic test_walk();
        load(8'h05, 2'h0, 16'h2024, 2'h1);
        load(8'h06, 2'h0, 16'h2024, 2'h2);
        load(8'h02, 2'h2, 16'h8012, 2'h0);
        load(8'h0a, 2'h0, 16'h2480, 2'h3);
        send(8'h05, 16'h2024, RLLC_ST2);
        send(8'h01, 16'h2012, RLLC_ST1);
        send(8'h06, 16'h2024, RLLC_ST3);
        send(8'h01, 16'h8120, RLLC_ST3);
        send(8'h02, 16'h8012, RLLC_ST1);
        send(8'h0a, 16'h2480, RLLC_ST4);
        send(8'h01, 16'h8120, RLLC_ST3);
        drain_cmp('{9'h001, 9'h005, 9'h001, 9'h006, 9'h001, 9'h002, 9'h00a});
        $display("test walk done");
    endtask : test_walk
    task automatic test_miss();
        // Channel copies a word one edge after code_valid, so corrupt spans that edge
        corrupt = 1'b1;
        send(8'h01, 16'h8120, RLLC_ST3);
        send(8'h02, 16'h8012, RLLC_ST1);
        corrupt = 1'b0;
        send(8'h01, 16'h2012, RLLC_ST1);
        // Corrupted word finds no entry, reported with byte zero
        drain_cmp('{9'h001, 9'h100, 9'h002});
        $display("test miss done");
    endtask : test_miss
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        test_reset();
        test_builtin();
        test_walk();
        test_miss();
        give_verdict();
    end
    // Whole run is under a hundred cycles; this allows twenty times that
    initial begin
        #8000;
        n_errors++;
        give_verdict();
    end
endmodule : rllc_codec_tb
`default_nettype wire
